// [design/csb_pkg.sv]
/*
 Constants for the channel status block buffer: register map, field positions,
 reset values, block geometry, check byte polynomial and FIFO defaults.
 Assumes a 32-bit APB bus with byte addresses and one register per aligned word.
*/
// Functional notes
// - Keep one 192-bit status block per subframe channel and as much again for user bits.
// - Status data passes through two block-sized buffers in series, staging then transmit.
// - Software reads and writes the staging buffer through registers on the bus.
// - Only the transmit buffer feeds the serial bits, save status bits in hardware mode and a professional check byte; it changes only by whole-block copies.
// - Block copies happen on the output frame timebase, at a block boundary, before sending.
// - The top bit of every stored status byte goes out first; user words go out top bit first, odd bits to A, even bits to B.
// - Byte zero of the channel A block sits at address 20h, its top bit being the professional flag.
// - Every block copy raises an event when the event enable bit is set.
// - While the inhibit bit is set no block copy takes place.
// - A professional block gets its check byte computed by the block, not written by software.
// - The check byte is also generated when status bits arrive on the serial pin in hardware mode.
// - The status staging buffer is 24 words of 16 bits, channel A in the upper byte, channel B in the lower; user words put A on odd bits.
package csb_pkg;
    // Block geometry
    localparam int       CSB_WORDS      = 24;
    localparam logic [7:0] CSB_LAST_BIT = 8'hBF;
    localparam logic [7:0] CSB_CRC_FIRST = 8'hB8;
    // Byte addresses and word indexes
    localparam logic [7:0] CSB_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CSB_STAT_ADDR = 8'h04;
    localparam logic [7:0] CSB_CBUF_ADDR = 8'h20;
    localparam logic [7:0] CSB_UBUF_ADDR = 8'h80;
    localparam logic [5:0] CSB_CTRL_IDX  = CSB_CTRL_ADDR[7:2];
    localparam logic [5:0] CSB_STAT_IDX  = CSB_STAT_ADDR[7:2];
    localparam logic [5:0] CSB_CBUF_IDX  = CSB_CBUF_ADDR[7:2];
    localparam logic [5:0] CSB_CBUF_END  = 6'h20;
    localparam logic [5:0] CSB_UBUF_IDX  = CSB_UBUF_ADDR[7:2];
    localparam logic [5:0] CSB_UBUF_END  = 6'h38;
    // Control fields
    localparam int CSB_CTRL_INHIBIT = 0;
    localparam int CSB_CTRL_EVT_EN  = 1;
    // Check byte generator
    localparam logic [7:0] CSB_CRC_INIT = 8'hFF;
    localparam logic [7:0] CSB_CRC_POLY = 8'h1D;
    // Write FIFO: word index plus 16 data bits
    localparam int CSB_FIFO_DEPTH = 16;
    localparam int CSB_FIFO_WIDTH = 22;
endpackage

// [design/csb_fifo.sv]
/*
 Synchronous FIFO with valid/ready on both sides and an occupancy count.
 Assumes one clock, asynchronous active-low reset, and a clock enable that freezes it.
*/
`timescale 1ns/10ps
module csb_fifo
    import csb_pkg::*;
#(
    parameter int WIDTH = CSB_FIFO_WIDTH,
    parameter int DEPTH = CSB_FIFO_DEPTH
) (
    input  logic                     pclk,      // Clock
    input  logic                     presetn,   // Async reset, low
    input  logic                     ce,        // Clock enable
    input  logic                     in_valid,  // Push request
    output logic                     in_ready,  // Room available
    input  logic [WIDTH-1:0]         in_data,   // Push data
    output logic                     out_valid, // Data available
    input  logic                     out_ready, // Pop request
    output logic [WIDTH-1:0]         out_data,  // Head entry
    output logic [$clog2(DEPTH):0]   level      // Entries held
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("csb_fifo DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } csb_fifo_state_type;

    csb_fifo_state_type state_ff;
    csb_fifo_state_type nxt_state;
    logic               push;
    logic               pop;

    // Flags and head
    assign in_ready  = state_ff.count != (AW + 1)'(DEPTH);
    assign out_valid = state_ff.count != '0;
    assign out_data  = state_ff.mem[state_ff.rd_ptr];
    assign level     = state_ff.count;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.mem[state_ff.wr_ptr] = in_data;
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            nxt_state.count = state_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_state.count = state_ff.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    a_fifo_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff.count <= (AW + 1)'(DEPTH))
        else $error("FIFO count above depth");
endmodule

// [design/csb_crc.sv]
/*
 Serial generator of the status block check byte, one bit per frame.
 Assumes the caller starts it on bit 0 and shifts it for each bit before the check byte.
*/
`timescale 1ns/10ps
module csb_crc
    import csb_pkg::*;
(
    input  logic       pclk,    // Clock
    input  logic       presetn, // Async reset, low
    input  logic       ce,      // Clock enable
    input  logic       start,   // First bit of block
    input  logic       shift,   // Bit to absorb
    input  logic       bit_in,  // Serial bit
    output logic [7:0] crc      // Running check byte
);
    typedef struct packed {
        logic [7:0] crc;
    } csb_crc_state_type;

    csb_crc_state_type state_ff;
    csb_crc_state_type nxt_state;
    logic [7:0]        seed;
    logic              fb;

    assign crc = state_ff.crc;

    // Polynomial x^8+x^4+x^3+x^2+1, preset to ones
    always_comb begin
        nxt_state = state_ff;
        seed = start ? CSB_CRC_INIT : state_ff.crc;
        fb = bit_in ^ seed[7];
        if (start || shift) begin
            nxt_state.crc = {seed[6:0], 1'b0} ^ (fb ? CSB_CRC_POLY : 8'h00);
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end
endmodule

// [design/csb_top.sv]
/*
 Channel status block buffer: APB register slave, staging and transmit buffers
 for status and user bits, frame-timed block copy and serial bit output.
 Assumes frame_tick pulses once per frame and block_start marks frame 0, both synchronous to pclk.
*/
`timescale 1ns/10ps
module csb_top
    import csb_pkg::*;
#(
    parameter int FIFO_DEPTH = CSB_FIFO_DEPTH
) (
    input  logic        pclk,        // APB clock, 40 MHz
    input  logic        presetn,     // Async reset, low
    input  logic        ce,          // Clock enable
    input  logic        psel,        // APB select
    input  logic        penable,     // APB access phase
    input  logic        pwrite,      // APB write
    input  logic [7:0]  paddr,       // APB byte address
    input  logic [31:0] pwdata,      // APB write data
    output logic [31:0] prdata,      // APB read data
    output logic        pready,      // APB ready
    output logic        pslverr,     // APB error
    input  logic        frame_tick,  // One pulse per frame
    input  logic        block_start, // Frame 0 of block
    input  logic        hw_mode,     // Status bits from pin
    input  logic        hw_cs_in,    // Serial status bit
    output logic        cs_a,        // Status bit, channel A
    output logic        cs_b,        // Status bit, channel B
    output logic        u_a,         // User bit, channel A
    output logic        u_b,         // User bit, channel B
    output logic        xfer_event   // Block copy pulse
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (FIFO_DEPTH > 128) begin : g_depth_check
        $error("csb_top FIFO_DEPTH above 128 does not fit the status field");
    end

    typedef logic [CSB_WORDS-1:0][15:0] csb_block_type;

    typedef struct packed {
        csb_block_type stage_c;
        csb_block_type tx_c;
        csb_block_type stage_u;
        csb_block_type tx_u;
        logic          inhibit;
        logic          evt_en;
        logic [7:0]    bit_idx;
        logic [7:0]    xfer_cnt;
        logic          pro_a;
        logic          pro_b;
        logic          cs_a;
        logic          cs_b;
        logic          u_a;
        logic          u_b;
        logic          xfer_evt;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
    } csb_state_type;

    csb_state_type                 state_ff;
    csb_state_type                 nxt_state;
    logic [5:0]                    req_idx;
    logic                          req_ok;
    logic                          access;
    logic                          fifo_in_valid;
    logic                          fifo_in_ready;
    logic                          fifo_out_valid;
    logic                          fifo_out_ready;
    logic [CSB_FIFO_WIDTH-1:0]     fifo_out_data;
    logic [LW-1:0]                 fifo_level;
    logic [5:0]                    fifo_idx;
    logic [15:0]                   fifo_wdata;
    logic [5:0]                    drain_c;
    logic [5:0]                    drain_u;
    logic [5:0]                    rd_c;
    logic [5:0]                    rd_u;
    logic [31:0]                   stat_word;
    logic [31:0]                   rd_data;
    logic                          boundary;
    logic                          xfer_now;
    logic [7:0]                    nxt_idx;
    csb_block_type                 src_c;
    csb_block_type                 src_u;
    logic [4:0]                    sel_word;
    logic [2:0]                    sel_bit;
    logic                          raw_a;
    logic                          raw_b;
    logic                          in_crc;
    logic                          crc_start;
    logic                          crc_shift;
    logic [7:0]                    crc_a;
    logic [7:0]                    crc_b;

    // Outputs straight from the state register
    assign prdata     = state_ff.prdata;
    assign pready     = state_ff.pready;
    assign pslverr    = state_ff.pslverr;
    assign cs_a       = state_ff.cs_a;
    assign cs_b       = state_ff.cs_b;
    assign u_a        = state_ff.u_a;
    assign u_b        = state_ff.u_b;
    assign xfer_event = state_ff.xfer_evt;

    // Address decode, unmapped words answer with an error
    assign req_idx = paddr[7:2];
    assign req_ok  = (paddr[1:0] == 2'h0)
                   && ((req_idx == CSB_CTRL_IDX) || (req_idx == CSB_STAT_IDX)
                   || (req_idx >= CSB_CBUF_IDX && req_idx < CSB_CBUF_END)
                   || (req_idx >= CSB_UBUF_IDX && req_idx < CSB_UBUF_END));
    assign access  = psel & penable & ~state_ff.pready;

    // Writes queue in the FIFO; a full FIFO holds pready low
    assign fifo_in_valid  = access & pwrite & req_ok;
    assign fifo_out_ready = ~xfer_now;
    assign fifo_idx       = fifo_out_data[21:16];
    assign fifo_wdata     = fifo_out_data[15:0];
    assign drain_c        = fifo_idx - CSB_CBUF_IDX;
    assign drain_u        = fifo_idx - CSB_UBUF_IDX;

    csb_fifo #(
        .WIDTH (CSB_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({req_idx, pwdata[15:0]}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // Read mux: control, status, then the two staging buffers
    assign rd_c      = req_idx - CSB_CBUF_IDX;
    assign rd_u      = req_idx - CSB_UBUF_IDX;
    assign stat_word = {6'h00, state_ff.pro_a, state_ff.inhibit, 8'(fifo_level),
                        state_ff.xfer_cnt, state_ff.bit_idx};
    assign rd_data   = (req_idx == CSB_CTRL_IDX) ? {30'h0, state_ff.evt_en, state_ff.inhibit}
                     : (req_idx == CSB_STAT_IDX) ? stat_word
                     : (req_idx < CSB_UBUF_IDX)  ? {16'h0000, state_ff.stage_c[rd_c[4:0]]}
                     : {16'h0000, state_ff.stage_u[rd_u[4:0]]};

    // Frame timebase: boundary, copy decision and next bit position
    assign boundary = block_start | (state_ff.bit_idx == CSB_LAST_BIT);
    assign xfer_now = frame_tick & boundary & ~state_ff.inhibit;
    assign nxt_idx  = boundary ? 8'h00 : state_ff.bit_idx + 8'h01;
    assign src_c    = xfer_now ? state_ff.stage_c : state_ff.tx_c;
    assign src_u    = xfer_now ? state_ff.stage_u : state_ff.tx_u;
    assign sel_word = nxt_idx[7:3];
    assign sel_bit  = ~nxt_idx[2:0];

    // Byte top bit first; A in upper byte, B in lower
    assign raw_a     = hw_mode ? hw_cs_in : src_c[sel_word][{1'b1, sel_bit}];
    assign raw_b     = hw_mode ? hw_cs_in : src_c[sel_word][{1'b0, sel_bit}];
    assign in_crc    = nxt_idx >= CSB_CRC_FIRST;
    assign crc_start = frame_tick & (nxt_idx == 8'h00);
    assign crc_shift = frame_tick & ~in_crc;

    csb_crc u_crc_a (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .start   (crc_start),
        .shift   (crc_shift),
        .bit_in  (raw_a),
        .crc     (crc_a)
    );

    csb_crc u_crc_b (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .start   (crc_start),
        .shift   (crc_shift),
        .bit_in  (raw_b),
        .crc     (crc_b)
    );

    // Next state: bus answer, FIFO drain, frame step
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pready = 1'b0;
        nxt_state.pslverr = 1'b0;
        nxt_state.xfer_evt = 1'b0;
        if (access) begin
            if (!req_ok) begin
                nxt_state.pready = 1'b1;
                nxt_state.pslverr = 1'b1;
                nxt_state.prdata = 32'h00000000;
            end else if (pwrite) begin
                nxt_state.pready = fifo_in_ready;
            end else if (!fifo_out_valid) begin
                nxt_state.pready = 1'b1;
                nxt_state.prdata = rd_data;
            end
        end
        if (fifo_out_valid && !xfer_now) begin
            if (fifo_idx == CSB_CTRL_IDX) begin
                nxt_state.inhibit = fifo_wdata[CSB_CTRL_INHIBIT];
                nxt_state.evt_en = fifo_wdata[CSB_CTRL_EVT_EN];
            end else if (fifo_idx >= CSB_CBUF_IDX && fifo_idx < CSB_CBUF_END) begin
                nxt_state.stage_c[drain_c[4:0]] = fifo_wdata;
            end else if (fifo_idx >= CSB_UBUF_IDX && fifo_idx < CSB_UBUF_END) begin
                nxt_state.stage_u[drain_u[4:0]] = fifo_wdata;
            end
        end
        if (frame_tick) begin
            nxt_state.bit_idx = nxt_idx;
            if (xfer_now) begin
                nxt_state.tx_c = state_ff.stage_c;
                nxt_state.tx_u = state_ff.stage_u;
                nxt_state.xfer_cnt = state_ff.xfer_cnt + 8'h01;
                nxt_state.xfer_evt = state_ff.evt_en;
            end
            if (nxt_idx == 8'h00) begin
                nxt_state.pro_a = raw_a;
                nxt_state.pro_b = raw_b;
            end
            nxt_state.cs_a = (in_crc && state_ff.pro_a) ? crc_a[sel_bit] : raw_a;
            nxt_state.cs_b = (in_crc && state_ff.pro_b) ? crc_b[sel_bit] : raw_b;
            nxt_state.u_a = src_u[sel_word][{sel_bit, 1'b1}];
            nxt_state.u_b = src_u[sel_word][{sel_bit, 1'b0}];
        end
    end

    // State register; first frame after reset opens a block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.bit_idx <= CSB_LAST_BIT;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    a_inhibit_no_copy: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && frame_tick && state_ff.inhibit) |=> (state_ff.xfer_cnt == $past(state_ff.xfer_cnt)))
        else $error("Block copied while inhibited");

    a_copy_whole_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && xfer_now) |=> (state_ff.tx_c == $past(state_ff.stage_c)) && !state_ff.inhibit)
        else $error("Transmit buffer differs from staged block");

    a_copy_on_frame: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && !(frame_tick && boundary)) |=> (state_ff.tx_c == $past(state_ff.tx_c)))
        else $error("Transmit buffer changed off a block boundary");

    a_copy_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && xfer_now) |=> (state_ff.xfer_evt == $past(state_ff.evt_en)))
        else $error("Copy event missing or unwanted");

    a_pro_bit_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && frame_tick && !hw_mode && !xfer_now && nxt_idx == 8'h00)
        |=> (cs_a == $past(state_ff.tx_c[0][15])) && (state_ff.pro_a == cs_a))
        else $error("Block did not open with byte 0 top bit");

    a_msb_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && frame_tick && !hw_mode && !xfer_now && nxt_idx == 8'h09)
        |=> (cs_b == $past(state_ff.tx_c[1][6])))
        else $error("Bit order within byte wrong");

    a_check_byte: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && frame_tick && nxt_idx == CSB_CRC_FIRST && state_ff.pro_a)
        |=> (cs_a == $past(crc_a[7])))
        else $error("Check byte not sent in professional block");

    a_serial_pass: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && frame_tick && hw_mode && !in_crc) |=> (cs_a == $past(hw_cs_in)) && (cs_b == cs_a))
        else $error("Serial status bit not passed");

    a_stage_layout: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && fifo_out_valid && !xfer_now && fifo_idx == CSB_CBUF_IDX)
        |=> (state_ff.stage_c[0] == $past(fifo_wdata)))
        else $error("Staging word 0 not written");

    a_read_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && access && !pwrite && req_ok && !fifo_out_valid) |=> pready && !pslverr)
        else $error("Read not answered");
endmodule

// [verif/csb_host_bfm.sv]
/*
 APB master model standing in for the host controller of the status buffer.
 Assumes the slave answers with pready; the caller checks the returned ok flag.
*/
`timescale 1ns/10ps
module csb_host_bfm (
    input  wire logic        pclk,    // Clock
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Direction
    output logic [7:0]       paddr,   // Byte address
    output logic [31:0]      pwdata,  // Write data
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pready,  // Ready
    input  wire logic        pslverr  // Error
);
    // Idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
    end

    // One transfer, held until pready is seen at a rising edge or 64 edges pass
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~wd; // Stale data must not look valid
    endtask
endmodule

// [verif/tb.sv]
/*
 Self-checking bench for the status block buffer: register rows, block copy,
 inhibit, event enable, check byte in buffer and pin mode, reset.
 Assumes the host model above and frame ticks made by the bench.
*/
`timescale 1ns/10ps
module tb import csb_pkg::*;;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } csb_row_type;
    localparam csb_row_type ROWS [13] = '{
        '{1'b1, 8'h00, 32'h00000003, 32'h00000000, 1'b0}, '{1'b0, 8'h00, 32'h00000000, 32'h00000003, 1'b0},
        '{1'b1, 8'h20, 32'h0000A55A, 32'h00000000, 1'b0}, '{1'b0, 8'h20, 32'h00000000, 32'h0000A55A, 1'b0},
        '{1'b1, 8'h7C, 32'h00005533, 32'h00000000, 1'b0}, '{1'b0, 8'h7C, 32'h00000000, 32'h00005533, 1'b0},
        '{1'b1, 8'hDC, 32'h0000AAAA, 32'h00000000, 1'b0}, '{1'b0, 8'hDC, 32'h00000000, 32'h0000AAAA, 1'b0},
        '{1'b1, 8'h10, 32'h00000001, 32'h00000000, 1'b1}, '{1'b0, 8'h22, 32'h00000000, 32'h00000000, 1'b1},
        '{1'b1, 8'h04, 32'h000000FF, 32'h00000000, 1'b0}, '{1'b0, 8'h00, 32'h00000000, 32'h00000003, 1'b0},
        '{1'b0, 8'h04, 32'h00000000, 32'h010000BF, 1'b0}};
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        frame_tick, block_start, hw_mode, hw_cs_in, cs_a, cs_b, u_a, u_b, xfer_event, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          fail_count, n_tests, i;

    csb_top #(.FIFO_DEPTH(CSB_FIFO_DEPTH)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_tick(frame_tick), .block_start(block_start), .hw_mode(hw_mode),
        .hw_cs_in(hw_cs_in), .cs_a(cs_a), .cs_b(cs_b), .u_a(u_a), .u_b(u_b), .xfer_event(xfer_event));
    csb_host_bfm u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus cycle; a lost answer ends the run
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        u_host.xfer(wr, a, d, rd, er, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR pready expected 1 seen 0");
            final_report();
        end
    endtask
    // One frame; outputs are settled on return
    task automatic tick(input logic bs, input logic hb);
        @(posedge pclk);
        frame_tick  <= 1'b1;
        block_start <= bs;
        hw_cs_in    <= hb;
        @(posedge pclk);
        frame_tick  <= 1'b0;
        block_start <= 1'b0;
        #1;
    endtask
    // Whole block: A pro with 0x55 tail, B consumer with 0x33 tail; in pin mode B carries the same pro stream as A
    task automatic run_block(input logic hw);
        logic [7:0] ea [24];
        logic [7:0] c;
        logic       ab;
        int         n;
        foreach (ea[n]) ea[n] = 8'h00;
        ea[0] = 8'h80;
        ea[23] = 8'h55;
        c = CSB_CRC_INIT;
        for (n = 0; n < 184; n++) c = {c[6:0], 1'b0} ^ ((c[7] ^ ea[n/8][7-n%8]) ? CSB_CRC_POLY : 8'h00);
        @(posedge pclk);
        hw_mode <= hw;
        for (n = 0; n < 192; n++) begin
            tick(n == 0, ea[n/8][7-n%8]);
            ab = (n >= 184) ? c[191-n] : ea[n/8][7-n%8];
            chk1("cs_a", ab, cs_a);
            chk1("cs_b", hw ? ab : (n >= 184 && 8'h33 >> (191 - n) & 1), cs_b);
            chk1("u_a", n >= 184, u_a);
            chk1("u_b", 1'b0, u_b);
        end
    endtask

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        frame_tick = 1'b0;
        block_start = 1'b0;
        hw_mode = 1'b0;
        hw_cs_in = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        chk1("pready", 1'b0, pready);
        chk1("xfer_event", 1'b0, xfer_event);
        presetn <= 1'b1;
        // Register rows
        foreach (ROWS[i]) begin
            bus(ROWS[i].wr, ROWS[i].addr, ROWS[i].wdata);
            chk1("pslverr", ROWS[i].err, er);
            if (!ROWS[i].wr) chk32("prdata", ROWS[i].rdata, rd);
        end
        // First block copy, byte zero top bit first
        bus(1'b1, CSB_CTRL_ADDR, 32'h00000002);
        for (i = 0; i < 8; i++) begin
            tick(i == 0, 1'b0);
            chk1("cs_a", 8'hA5 >> (7 - i) & 1, cs_a);
            chk1("cs_b", 8'h5A >> (7 - i) & 1, cs_b);
            chk1("xfer_event", i == 0, xfer_event);
        end
        // Inhibited copy keeps the old block
        bus(1'b1, CSB_CTRL_ADDR, 32'h00000003);
        bus(1'b1, CSB_CBUF_ADDR, 32'h00000000);
        tick(1'b1, 1'b0);
        chk1("cs_a", 1'b1, cs_a);
        chk1("xfer_event", 1'b0, xfer_event);
        bus(1'b1, CSB_CTRL_ADDR, 32'h00000002);
        // Clock enable low: frame ignored, no copy
        ce <= 1'b0;
        tick(1'b1, 1'b0);
        chk1("cs_a", 1'b1, cs_a);
        chk1("xfer_event", 1'b0, xfer_event);
        @(posedge pclk);
        ce <= 1'b1;
        tick(1'b1, 1'b0);
        chk1("cs_a", 1'b0, cs_a);
        chk1("xfer_event", 1'b1, xfer_event);
        bus(1'b1, CSB_CTRL_ADDR, 32'h00000000);
        tick(1'b1, 1'b0);
        chk1("xfer_event", 1'b0, xfer_event);
        // Check byte, buffer then pin source
        bus(1'b1, CSB_CBUF_ADDR, 32'h00008000);
        bus(1'b1, CSB_CTRL_ADDR, 32'h00000002);
        run_block(1'b0);
        run_block(1'b1);
        // Reset in mid-run, driven and released at clock edges
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk1("cs_a", 1'b0, cs_a);
        chk1("u_a", 1'b0, u_a);
        @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, CSB_CTRL_ADDR, 32'h00000000);
        chk32("ctrl", 32'h00000000, rd);
        final_report();
    end
endmodule
